// ### idle_mode_wake_sequencer_regs.svh
`ifndef IDLE_MODE_WAKE_SEQUENCER_REGS_SVH
`define IDLE_MODE_WAKE_SEQUENCER_REGS_SVH

// Register offsets
`define CTRL_ADDR            4'h0
`define STATUS_ADDR          4'h4

// Control word field positions
`define CTRL_IDLE_BIT        0
`define CTRL_CHOICE_LO       1
`define CTRL_CHOICE_HI       2
`define CTRL_FREQ_LSB        3
`define CTRL_FREQ_MSB        5
`define CTRL_SLOW_ORIGIN_BIT 6
`define CTRL_AUX_EN_BIT      7
`define CTRL_WDOG_EN_BIT     8
`define CTRL_FAILSAFE_BIT    9
`define CTRL_WIDTH           10

// Reset values; frequency code 3'h3 stands for 1 MHz
`define CTRL_RESET           10'h018
`define FREQ_RESET           3'h3

// Timing, in ns unless named otherwise
`define CLK_PERIOD_NS        10
`define CPU_START_DELAY_NS   2000
`define SETTLE_TIME_NS       5000
`define OST_TIME_NS          10000
`define PLL_LOCK_TIME_NS     200000

`endif

// ### idle_mode_wake_sequencer_pkg.sv
package idle_mode_wake_sequencer_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  typedef enum logic [1:0] {
    SRC_PRIMARY,
    SRC_AUX,
    SRC_INTERNAL
  } clk_src_e;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_IDLE,
    ST_SLEEP,
    ST_WAKE
  } seq_state_e;

  typedef struct packed {
    logic       failsafe_enable;
    logic       watchdog_enable;
    logic       aux_osc_enable;
    logic       slow_origin_choice;
    logic [2:0] internal_freq_choice;
    logic [1:0] clock_choice;
    logic       idle_on_sleep;
  } ctrl_s;

  typedef struct packed {
    logic       primary_ready_flag;
    logic       aux_running_flag;
    logic       internal_osc_stable;
  } flags_s;

endpackage : idle_mode_wake_sequencer_pkg

// ### idle_mode_wake_sequencer.sv
// Function
// - Idle sleep gates CPU, peripherals keep source
// - Idle keeps watchdog and aux oscillators running
// - Only interrupt, watchdog or reset wakes idle
// - Hold execution for CPU start delay
// - Resume on idle source, control bits kept
// - Watchdog in idle/sleep wakes to run
// - Primary idle keeps primary clock and ready
// - Aux idle: primary off, ready clear, aux set
// - Aux disabled: keep previous clock's idle mode
// - Upper choice bit selects internal; lower ignored
// - Switch to internal stops primary, clears ready
// - Fast oscillator enable and stable flag settle
// - Slow oscillator runs for watchdog, or for monitor only on internal source
// - Enabled interrupt flag starts exit sequence
// - Interrupt wake: next instruction, vector if enabled
// - Watchdog while running causes watchdog reset
// - Watchdog cleared on sleep, clear, loss, freq
// - Reset exit restarts at address zero
// - No start-up timer from primary idle/non-crystal
// - Reset exit delay depends on target clock
// - Delays concurrent; fast oscillator defaults 1 MHz
`include "idle_mode_wake_sequencer_regs.svh"

module idle_mode_wake_sequencer #(
  parameter int IRQ_N       = 8,
  parameter int CSD_NS      = `CPU_START_DELAY_NS,
  parameter int SETTLE_NS   = `SETTLE_TIME_NS,
  parameter int OST_NS      = `OST_TIME_NS,
  parameter int PLL_CYCLES  = (`PLL_LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [15:0]      reg_rdata,
  input  wire logic             sleep_instr,
  input  wire logic             watchdog_clear_instr,
  input  wire logic             watchdog_timeout,
  input  wire logic             clock_lost,
  input  wire logic [IRQ_N-1:0] irq_flags,
  input  wire logic [IRQ_N-1:0] irq_enables,
  input  wire logic [IRQ_N-1:0] irq_peripheral,
  input  wire logic             peripheral_irq_enable,
  input  wire logic             global_irq_enable,
  input  wire logic             primary_is_crystal,
  input  wire logic             primary_has_pll,
  output logic                  cpu_clock_en,
  output logic                  periph_clock_en,
  output logic      [1:0]       clock_source,
  output logic                  primary_osc_en,
  output logic                  aux_osc_run,
  output logic                  slow_osc_run,
  output logic                  fast_osc_en,
  output logic                  watchdog_clear,
  output logic                  watchdog_reset_req,
  output logic                  exec_resume,
  output logic                  vector_branch,
  output logic                  restart_at_zero
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts, least times rounded up

  localparam int P       = `CLK_PERIOD_NS;
  localparam int CSD_C   = (CSD_NS + P - 1) / P < 1 ? 1 : (CSD_NS + P - 1) / P;
  localparam int SET_C   = (SETTLE_NS + P - 1) / P < 1 ? 1 : (SETTLE_NS + P - 1) / P;
  localparam int OST_C   = (OST_NS + P - 1) / P < 1 ? 1 : (OST_NS + P - 1) / P;
  localparam int CW      = 32;

  localparam logic [CW-1:0] CSD_W  = CW'(CSD_C);
  localparam logic [CW-1:0] SET_W  = CW'(SET_C);
  localparam logic [CW-1:0] OST_W  = CW'(OST_C);
  localparam logic [CW-1:0] PLL_W  = CW'(PLL_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // State

  idle_mode_wake_sequencer_pkg::ctrl_s      ctrl_r;
  idle_mode_wake_sequencer_pkg::flags_s     flags_r;
  idle_mode_wake_sequencer_pkg::seq_state_e state_r;
  idle_mode_wake_sequencer_pkg::clk_src_e   src_r;
  idle_mode_wake_sequencer_pkg::clk_src_e   sleep_src;
  idle_mode_wake_sequencer_pkg::clk_src_e   choice_src;

  logic [CW-1:0] wake_cnt_r;
  logic [CW-1:0] settle_cnt_r;
  logic [CW-1:0] exit_delay;
  logic          load_pending_r;
  logic          from_reset_r;
  logic          from_idle_r;
  logic          irq_wake_r;
  logic          irq_pending;
  logic          wake_evt;
  logic          ctrl_wr;
  logic          fast_want;
  logic          wake_done;

  assign ctrl_wr   = reg_wr && (reg_addr == `CTRL_ADDR);
  assign wake_done = (state_r == idle_mode_wake_sequencer_pkg::ST_WAKE) &&
                     !load_pending_r && (wake_cnt_r <= CW'(1));

  ////////////////////////////////////////////////////////////////////////////
  // Wake sources

  // Peripheral sources also need the peripheral gate
  assign irq_pending = |(irq_flags & irq_enables &
                         (~irq_peripheral | {IRQ_N{peripheral_irq_enable}}));
  // Nothing else but reset may restart the CPU clock
  assign wake_evt = irq_pending || watchdog_timeout;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection

  always_comb begin
    if (ctrl_r.clock_choice[1])
      choice_src = idle_mode_wake_sequencer_pkg::SRC_INTERNAL;
    else if (ctrl_r.clock_choice[0])
      choice_src = idle_mode_wake_sequencer_pkg::SRC_AUX;
    else
      choice_src = idle_mode_wake_sequencer_pkg::SRC_PRIMARY;
  end

  // Aux request with aux oscillator off keeps the running clock
  always_comb begin
    if (choice_src == idle_mode_wake_sequencer_pkg::SRC_AUX && !ctrl_r.aux_osc_enable)
      sleep_src = src_r;
    else
      sleep_src = choice_src;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exit delay; the CPU start delay overlaps the others

  always_comb begin
    exit_delay = CSD_W;
    if (!from_idle_r && src_r == idle_mode_wake_sequencer_pkg::SRC_PRIMARY &&
        primary_is_crystal) begin
      if (primary_has_pll)
        exit_delay = OST_W + PLL_W;
      else
        exit_delay = OST_W;
      if (exit_delay < CSD_W)
        exit_delay = CSD_W;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r <= idle_mode_wake_sequencer_pkg::ctrl_s'(`CTRL_RESET);
    end else if (ctrl_wr) begin
      ctrl_r <= idle_mode_wake_sequencer_pkg::ctrl_s'(reg_wdata[`CTRL_WIDTH-1:0]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CTRL_ADDR:   reg_rdata <= {6'h00, ctrl_r};
        `STATUS_ADDR: reg_rdata <= {8'h00, cpu_clock_en, state_r, src_r, flags_r};
        default:      reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r        <= idle_mode_wake_sequencer_pkg::ST_WAKE;
      src_r          <= idle_mode_wake_sequencer_pkg::SRC_PRIMARY;
      wake_cnt_r     <= '0;
      load_pending_r <= 1'b1;
      from_reset_r   <= 1'b1;
      from_idle_r    <= 1'b0;
      irq_wake_r     <= 1'b0;
    end else begin
      unique case (state_r)
        idle_mode_wake_sequencer_pkg::ST_RUN: begin
          if (sleep_instr) begin
            from_reset_r <= 1'b0;
            if (ctrl_r.idle_on_sleep) begin
              state_r     <= idle_mode_wake_sequencer_pkg::ST_IDLE;
              src_r       <= sleep_src;
              from_idle_r <= 1'b1;
            end else begin
              state_r     <= idle_mode_wake_sequencer_pkg::ST_SLEEP;
              from_idle_r <= 1'b0;
            end
          end else begin
            // Follows the choice field; aux waits for its enable
            src_r <= sleep_src;
          end
        end
        idle_mode_wake_sequencer_pkg::ST_IDLE,
        idle_mode_wake_sequencer_pkg::ST_SLEEP: begin
          if (wake_evt) begin
            state_r        <= idle_mode_wake_sequencer_pkg::ST_WAKE;
            load_pending_r <= 1'b1;
            irq_wake_r     <= irq_pending;
            // Watchdog wake lands in the mode the choice field names
            if (watchdog_timeout && !irq_pending)
              src_r <= choice_src;
          end
        end
        idle_mode_wake_sequencer_pkg::ST_WAKE: begin
          if (load_pending_r) begin
            wake_cnt_r     <= exit_delay;
            load_pending_r <= 1'b0;
          end else if (wake_cnt_r > CW'(1)) begin
            wake_cnt_r <= wake_cnt_r - CW'(1);
          end else begin
            // Idle source carries on as the run source
            state_r    <= idle_mode_wake_sequencer_pkg::ST_RUN;
            wake_cnt_r <= '0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gates and resume pulses

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpu_clock_en    <= 1'b0;
      periph_clock_en <= 1'b0;
      exec_resume     <= 1'b0;
      vector_branch   <= 1'b0;
      restart_at_zero <= 1'b0;
    end else begin
      exec_resume     <= wake_done && !from_reset_r;
      vector_branch   <= wake_done && !from_reset_r && irq_wake_r &&
                         global_irq_enable;
      restart_at_zero <= wake_done && from_reset_r;
      if (state_r == idle_mode_wake_sequencer_pkg::ST_RUN && sleep_instr) begin
        cpu_clock_en    <= 1'b0;
        periph_clock_en <= ctrl_r.idle_on_sleep;
      end else if (wake_done) begin
        // Execution starts on the cycle after the delay
        cpu_clock_en    <= 1'b1;
        periph_clock_en <= 1'b1;
      end else if (state_r == idle_mode_wake_sequencer_pkg::ST_WAKE && from_idle_r) begin
        periph_clock_en <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillators and ready flags

  assign fast_want = (ctrl_r.internal_freq_choice != 3'h0) ||
                     ctrl_r.slow_origin_choice;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      primary_osc_en <= 1'b1;
      aux_osc_run    <= 1'b0;
      slow_osc_run   <= 1'b0;
      fast_osc_en    <= 1'b0;
      clock_source   <= 2'h0;
    end else begin
      clock_source <= src_r;
      aux_osc_run  <= ctrl_r.aux_osc_enable;
      slow_osc_run <= ctrl_r.watchdog_enable ||
                      (ctrl_r.failsafe_enable &&
                       src_r == idle_mode_wake_sequencer_pkg::SRC_INTERNAL);
      // Sleep stops the primary and fast oscillators; aux follows its enable
      if (state_r == idle_mode_wake_sequencer_pkg::ST_SLEEP) begin
        primary_osc_en <= 1'b0;
        fast_osc_en    <= 1'b0;
      end else begin
        primary_osc_en <= (src_r == idle_mode_wake_sequencer_pkg::SRC_PRIMARY);
        fast_osc_en    <= (src_r == idle_mode_wake_sequencer_pkg::SRC_INTERNAL) &&
                          fast_want;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settle_cnt_r <= '0;
    end else if (!fast_osc_en) begin
      settle_cnt_r <= '0;
    end else if (settle_cnt_r < SET_W) begin
      settle_cnt_r <= settle_cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_r <= '0;
    end else if (state_r == idle_mode_wake_sequencer_pkg::ST_SLEEP) begin
      flags_r <= '0;
    end else begin
      flags_r.aux_running_flag <= (src_r == idle_mode_wake_sequencer_pkg::SRC_AUX);
      // Stable once settled; stays set while enabled
      flags_r.internal_osc_stable <= fast_osc_en && (settle_cnt_r >= SET_W);
      if (src_r != idle_mode_wake_sequencer_pkg::SRC_PRIMARY)
        flags_r.primary_ready_flag <= 1'b0;
      else if (wake_done || state_r == idle_mode_wake_sequencer_pkg::ST_RUN)
        flags_r.primary_ready_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog side effects

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      watchdog_clear     <= 1'b0;
      watchdog_reset_req <= 1'b0;
    end else begin
      watchdog_clear <= (state_r == idle_mode_wake_sequencer_pkg::ST_RUN && sleep_instr) ||
                        watchdog_clear_instr ||
                        (clock_lost && ctrl_r.failsafe_enable) ||
                        (ctrl_wr && src_r == idle_mode_wake_sequencer_pkg::SRC_INTERNAL &&
                         reg_wdata[`CTRL_FREQ_MSB:`CTRL_FREQ_LSB] !=
                         ctrl_r.internal_freq_choice);
      // Running code takes a reset, not a wake
      watchdog_reset_req <= watchdog_timeout &&
                            state_r == idle_mode_wake_sequencer_pkg::ST_RUN;
    end
  end

endmodule : idle_mode_wake_sequencer

// ### idle_mode_wake_sequencer_chk.sv
`include "idle_mode_wake_sequencer_regs.svh"
module idle_mode_wake_sequencer_chk #(
  parameter int CSD_NS = `CPU_START_DELAY_NS
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       sleep_instr,
  input wire logic       watchdog_timeout,
  input wire logic       cpu_clock_en,
  input wire logic       periph_clock_en,
  input wire logic [1:0] clock_source,
  input wire logic       primary_osc_en,
  input wire logic       watchdog_clear,
  input wire logic       watchdog_reset_req,
  input wire logic       exec_resume,
  input wire logic       vector_branch,
  input wire logic       restart_at_zero
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CSD = CSD_NS / `CLK_PERIOD_NS;
  logic [15:0] off_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Saturates so a long halt never wraps to a small count
  always_ff @(posedge clk_sys) begin
    if (rst || cpu_clock_en) begin
      off_r <= 16'h0;
    end else if (off_r != 16'hffff) begin
      off_r <= off_r + 16'h1;
    end
  end
  ////////////////////////////////////////
  property p_sleep; sleep_instr && cpu_clock_en |=> !cpu_clock_en && watchdog_clear; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep left core clocked");
  property p_wdog_run; watchdog_timeout && cpu_clock_en && !sleep_instr |=> watchdog_reset_req; endproperty
  a_wdog_run: assert property (p_wdog_run) else $error("no reset request on timeout");
  property p_wdog_idle; watchdog_timeout && !cpu_clock_en |=> !watchdog_reset_req; endproperty
  a_wdog_idle: assert property (p_wdog_idle) else $error("halted timeout gave reset");
  property p_resume; exec_resume |-> cpu_clock_en && periph_clock_en && !restart_at_zero; endproperty
  a_resume: assert property (p_resume) else $error("resume without clocks");
  property p_vector; vector_branch |-> exec_resume; endproperty
  a_vector: assert property (p_vector) else $error("vector branch outside resume");
  property p_delay; $rose(cpu_clock_en) |-> off_r >= CSD; endproperty
  a_delay: assert property (p_delay) else $error("core restarted too early");
  property p_cause; $rose(cpu_clock_en) |-> exec_resume || restart_at_zero; endproperty
  a_cause: assert property (p_cause) else $error("core restarted without wake");
  property p_primary; periph_clock_en && clock_source == 2'h0 |-> primary_osc_en; endproperty
  a_primary: assert property (p_primary) else $error("primary stopped while in use");
  property p_internal; periph_clock_en && clock_source == 2'h2 |-> !primary_osc_en; endproperty
  a_internal: assert property (p_internal) else $error("primary running on internal");
endmodule : idle_mode_wake_sequencer_chk

// ### idle_mode_wake_sequencer_partner.sv
module idle_mode_wake_sequencer_partner (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       fire,
  input  wire logic       to_watchdog,
  input  wire logic [2:0] src,
  input  wire logic [7:0] lag,
  input  wire logic       exec_resume,
  output logic      [7:0] irq_flags,
  output logic            watchdog_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_r;
  logic       armed_r;
  logic       wd_r;
  logic [2:0] src_r;
  wire        due = armed_r && wait_r == 8'h0 && !fire;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      armed_r <= 1'b0;
    end else if (fire) begin
      armed_r <= 1'b1;
      wait_r  <= lag;
      wd_r    <= to_watchdog;
      src_r   <= src;
    end else if (armed_r && wait_r != 8'h0) begin
      wait_r <= wait_r - 8'h1;
    end else begin
      armed_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    watchdog_timeout <= !rst && due && wd_r;
  end
  // Flag stays up until serviced, so a masked source keeps pending
  always_ff @(posedge clk_sys) begin
    if (rst || exec_resume) begin
      irq_flags <= 8'h0;
    end else if (due && !wd_r) begin
      irq_flags[src_r] <= 1'b1;
    end
  end
endmodule : idle_mode_wake_sequencer_partner

// ### idle_mode_wake_sequencer_tb.sv
`include "idle_mode_wake_sequencer_regs.svh"
module idle_mode_wake_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CSD_NS = 300;
  localparam int OST_NS = 500;
  localparam int SET_NS = 400;
  localparam int PLL    = 20;
  localparam int CSD    = CSD_NS / `CLK_PERIOD_NS;
  localparam int OSC_STARTUP_TIMER    = OST_NS / `CLK_PERIOD_NS;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        sleep_instr = 1'b0;
  logic        watchdog_clear_instr = 1'b0;
  logic        clock_lost = 1'b0;
  logic [7:0]  irq_enables = 8'h0;
  logic [7:0]  irq_peripheral = 8'hf0;
  logic        peripheral_irq_enable = 1'b0;
  logic        global_irq_enable = 1'b0;
  logic        primary_is_crystal = 1'b1;
  logic        primary_has_pll = 1'b0;
  logic        fire = 1'b0;
  logic        to_wd = 1'b0;
  logic [2:0]  src = 3'h0;
  logic [7:0]  lag = 8'h0;
  logic        rd_q = 1'b0;
  logic [15:0] reg_rdata;
  logic [7:0]  irq_flags;
  logic [1:0]  clock_source;
  logic        cpu_clock_en, periph_clock_en, primary_osc_en, aux_osc_run, slow_osc_run, fast_osc_en;
  logic        watchdog_clear, watchdog_reset_req, exec_resume, vector_branch, restart_at_zero, watchdog_timeout;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          seed = 27;
  logic [31:0] rd_exp_q[$];
  logic [31:0] wake_q[$];
  idle_mode_wake_sequencer #(.CSD_NS(CSD_NS), .SETTLE_NS(SET_NS), .OST_NS(OST_NS), .PLL_CYCLES(PLL)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_instr(sleep_instr),
    .watchdog_clear_instr(watchdog_clear_instr), .watchdog_timeout(watchdog_timeout),
    .clock_lost(clock_lost), .irq_flags(irq_flags), .irq_enables(irq_enables),
    .irq_peripheral(irq_peripheral), .peripheral_irq_enable(peripheral_irq_enable),
    .global_irq_enable(global_irq_enable), .primary_is_crystal(primary_is_crystal),
    .primary_has_pll(primary_has_pll), .cpu_clock_en(cpu_clock_en), .periph_clock_en(periph_clock_en),
    .clock_source(clock_source), .primary_osc_en(primary_osc_en), .aux_osc_run(aux_osc_run),
    .slow_osc_run(slow_osc_run), .fast_osc_en(fast_osc_en), .watchdog_clear(watchdog_clear),
    .watchdog_reset_req(watchdog_reset_req), .exec_resume(exec_resume), .vector_branch(vector_branch),
    .restart_at_zero(restart_at_zero)
  );
  idle_mode_wake_sequencer_partner i_partner (
    .clk_sys(clk_sys), .rst(rst), .fire(fire), .to_watchdog(to_wd), .src(src), .lag(lag),
    .exec_resume(exec_resume), .irq_flags(irq_flags), .watchdog_timeout(watchdog_timeout)
  );
  ////////////////////////////////////////
  task automatic chk_word(string what, logic [15:0] e, logic [15:0] got);
    comparisons++;
    if (got !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask : chk_word
  task automatic chk_wake(string what, logic [31:0] e, logic [31:0] got);
    comparisons++;
    if (got !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask : chk_wake
  task automatic tally_and_finish();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [15:0] e, logic [15:0] m);
    @(posedge clk_sys);
    rd_exp_q.push_back({m, e & m});
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic sleep_go();
    @(posedge clk_sys);
    sleep_instr <= 1'b1;
    @(posedge clk_sys);
    sleep_instr <= 1'b0;
    tick(2);
  endtask : sleep_go
  // Expected resume edge is taken from the edge the event is first sampled
  task automatic wake(logic wd, logic [2:0] s, logic go, logic [2:0] v);
    int k = 0;
    @(posedge clk_sys);
    fire  <= 1'b1;
    to_wd <= wd;
    src   <= s;
    lag   <= 8'($random(seed) & 15);
    @(posedge clk_sys);
    fire <= 1'b0;
    @(negedge clk_sys);
    while (!(wd ? watchdog_timeout === 1'b1 : irq_flags[s] === 1'b1) && k < 100) begin
      @(negedge clk_sys);
      k++;
    end
    if (go) begin
      wake_q.push_back({29'(cyc + CSD + 2), v});
    end
    tick(CSD + 6);
  endtask : wake
  task automatic do_reset(int dly);
    int k = 0;
    @(posedge clk_sys);
    rst <= 1'b1;
    tick(12);
    rst <= 1'b0;
    @(negedge clk_sys);
    while (restart_at_zero !== 1'b1 && k < 500) begin
      @(negedge clk_sys);
      k++;
    end
    chk_word("reset exit delay", 16'h1, 16'(k >= dly && k <= dly + 3));
    chk_word("core clock after reset", 16'h1, {15'h0, cpu_clock_en});
  endtask : do_reset
  ////////////////////////////////////////
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc  <= cyc + 1;
    rd_q <= reg_rd;
    if (cyc == 8000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  always @(negedge clk_sys) begin
    logic [31:0] e;
    if (rd_q === 1'b1 && rd_exp_q.size() > 0) begin
      e = rd_exp_q.pop_front();
      chk_word("reg_rdata", e[15:0], reg_rdata & e[31:16]);
    end
    if (exec_resume === 1'b1) begin
      e = wake_q.size() > 0 ? wake_q.pop_front() : 32'h0;
      chk_wake("exec_resume", e, {cyc[28:0], vector_branch, clock_source});
    end
  end
  initial begin
    logic [2:0] f;
    logic [2:0] s;
    logic       seen;
    do_reset(OSC_STARTUP_TIMER);
    rd(`CTRL_ADDR, 16'h0018, 16'h03ff);
    wr(`STATUS_ADDR, 16'hffff);
    rd(`STATUS_ADDR, 16'h0084, 16'h00fe);
    rd(4'h8, 16'h0000, 16'hffff);
    s = 3'($random(seed) & 3);
    irq_enables       <= 8'h1 << s;
    global_irq_enable <= 1'b1;
    wr(`CTRL_ADDR, 16'h0019);
    sleep_go();
    rd(`STATUS_ADDR, 16'h0024, 16'h00fe);
    watchdog_clear_instr <= 1'b1;
    clock_lost           <= 1'b1;
    @(posedge clk_sys);
    watchdog_clear_instr <= 1'b0;
    clock_lost           <= 1'b0;
    tick(CSD + 4);
    @(negedge clk_sys);
    chk_word("idle gates", 16'h1, {14'h0, cpu_clock_en, periph_clock_en});
    wake(1'b0, s, 1'b1, 3'h4);
    rd(`CTRL_ADDR, 16'h0019, 16'h03ff);
    global_irq_enable <= 1'b0;
    wr(`CTRL_ADDR, 16'h001b);
    sleep_go();
    rd(`STATUS_ADDR, 16'h0024, 16'h00fe);
    wake(1'b0, s, 1'b1, 3'h0);
    wr(`CTRL_ADDR, 16'h019b);
    sleep_go();
    rd(`STATUS_ADDR, 16'h002a, 16'h00fe);
    @(negedge clk_sys);
    chk_word("aux idle oscillators", 16'h2, {14'h0, aux_osc_run & slow_osc_run, primary_osc_en});
    wake(1'b1, 3'h0, 1'b1, 3'h1);
    wake(1'b1, 3'h0, 1'b0, 3'h0);
    f = 3'($random(seed)) | 3'h1;
    wr(`CTRL_ADDR, 16'h0201 | {10'h0, f, 3'h0});
    wr(`CTRL_ADDR, 16'h0207 | {10'h0, f, 3'h0});
    sleep_go();
    tick(SET_NS / `CLK_PERIOD_NS + 8);
    rd(`STATUS_ADDR, 16'h0031, 16'h00fd);
    @(negedge clk_sys);
    chk_word("internal idle oscillators", 16'h6, {13'h0, fast_osc_en, slow_osc_run, primary_osc_en});
    @(posedge clk_sys);
    s = 3'h4 | 3'($random(seed) & 3);
    irq_enables <= 8'h1 << s;
    wake(1'b0, s, 1'b0, 3'h0);
    @(negedge clk_sys);
    chk_word("masked peripheral", 16'h0, {15'h0, cpu_clock_en});
    @(posedge clk_sys);
    peripheral_irq_enable <= 1'b1;
    @(negedge clk_sys);
    wake_q.push_back({29'(cyc + CSD + 2), 3'h2});
    tick(CSD + 6);
    wr(`CTRL_ADDR, 16'h0206);
    seen = 1'b0;
    repeat (4) begin
      @(negedge clk_sys);
      seen = seen | watchdog_clear;
    end
    chk_word("frequency write clear", 16'h1, {15'h0, seen});
    chk_word("fast oscillator off", 16'h0, {15'h0, fast_osc_en});
    wr(`CTRL_ADDR, 16'h0207);
    wr(`CTRL_ADDR, 16'h0201);
    sleep_go();
    rd(`STATUS_ADDR, 16'h0024, 16'h00ff);
    wake(1'b0, s, 1'b1, 3'h0);
    @(posedge clk_sys);
    primary_has_pll <= 1'b1;
    do_reset(OSC_STARTUP_TIMER + PLL);
    chk_word("unmatched expectations", 16'h0, 16'(wake_q.size() + rd_exp_q.size()));
    tally_and_finish();
  end
endmodule : idle_mode_wake_sequencer_tb

bind idle_mode_wake_sequencer idle_mode_wake_sequencer_chk #(.CSD_NS(CSD_NS)) i_chk (
  .clk_sys(clk_sys), .rst(rst), .sleep_instr(sleep_instr), .watchdog_timeout(watchdog_timeout),
  .cpu_clock_en(cpu_clock_en), .periph_clock_en(periph_clock_en), .clock_source(clock_source),
  .primary_osc_en(primary_osc_en), .watchdog_clear(watchdog_clear), .watchdog_reset_req(watchdog_reset_req),
  .exec_resume(exec_resume), .vector_branch(vector_branch), .restart_at_zero(restart_at_zero)
);
